// ===== spc_regs.svh
// register offsets, field positions, reset values and counts of the serial port
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH
`define SPC_ADDR_SETUP    13'h0000
`define SPC_ADDR_VARIANT  13'h0003
`define SPC_ADDR_BANK     13'h0004
`define SPC_ADDR_UPDATE   13'h0232
`define SPC_SETUP_SEP_BIT 0
`define SPC_SETUP_LSB_BIT 1
`define SPC_SETUP_SRST_BIT 2
`define SPC_SETUP_LONG_BIT 3
`define SPC_BANK_ACT_BIT  0
`define SPC_UPDATE_BIT    0
`define SPC_SETUP_RST     8'h18
`define SPC_SETUP_SRST_VAL 8'h24
`define SPC_BANK_RST      8'h00
`define SPC_READ_ZERO     8'h00
`define SPC_INSTR_LAST    4'hf
`define SPC_BYTE_LAST     4'h7
`define SPC_RW_BIT        15
`endif

// ===== spc_pkg.sv
// types shared by the serial port modules
package spc_pkg;
    typedef logic [12:0] spc_addr_t;
    typedef logic [7:0]  spc_byte_t;
    typedef enum logic {
        SPC_ST_INSTR,
        SPC_ST_DATA
    } spc_state_e;
endpackage : spc_pkg

// ===== spc_link_if.sv
// link between the serial engine and the register file, all on the serial clock
interface spc_link_if;
    import spc_pkg::*;
    logic      wr_en;
    spc_addr_t addr;
    spc_byte_t wdata;
    spc_byte_t rdata;
    logic      lsb_first;
    logic      sep_read_pin;
    modport engine (output wr_en, output addr, output wdata,
                    input rdata, input lsb_first, input sep_read_pin);
    modport regs   (input wr_en, input addr, input wdata,
                    output rdata, output lsb_first, output sep_read_pin);
endinterface : spc_link_if

// ===== spc_serial_engine.sv
// serial shifter: instruction decode, data shifting and pin drive
`include "spc_regs.svh"
module spc_serial_engine import spc_pkg::*; (
    input  wire logic   i_sclk,
    input  wire logic   i_cs_n,
    input  wire logic   i_sdi,
    spc_link_if.engine  lnk,
    output logic        o_sdio_o,
    output logic        o_sdio_oe_n,
    output logic        o_sdo_o,
    output logic        o_sdo_oe_n
);
    logic [15:0] sh_q;
    logic [15:0] sh_d;
    logic [15:0] instr;
    logic [3:0]  cnt_q;
    spc_state_e  st_q;
    logic        rd_q;
    spc_addr_t   addr_q;
    logic        drive;
    logic        tx_bit;
    logic [15:0] sh_rev;

    // =========================================================
    // bit-reversed copy of the shifter for lsb-first frames
    for (genvar b = 0; b < 16; b++) begin : g_rev
        assign sh_rev[b] = sh_d[15 - b];
    end

    // =========================================================
    // decode
    always_comb begin
        sh_d  = {sh_q[14:0], i_sdi};
        instr = lnk.lsb_first ? sh_rev : sh_d; // [R5]
        // write lands in the same edge, so a frame may end right after it
        lnk.wr_en = (st_q == SPC_ST_DATA) && !rd_q && (cnt_q == `SPC_BYTE_LAST);
        lnk.addr  = addr_q;
        lnk.wdata = lnk.lsb_first ? sh_rev[15:8] : sh_d[7:0]; // [R5]
        drive  = (st_q == SPC_ST_DATA) && rd_q;
        tx_bit = lnk.rdata[lnk.lsb_first ? cnt_q[2:0] : 3'h7 - cnt_q[2:0]]; // [R5]
    end

    // =========================================================
    // receive side, cleared while the frame is idle
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            sh_q   <= 16'h0000;
            cnt_q  <= 4'h0;
            st_q   <= SPC_ST_INSTR;
            rd_q   <= 1'b0;
            addr_q <= 13'h0000;
        end else begin
            sh_q <= sh_d;
            unique case (st_q)
                SPC_ST_INSTR: begin
                    // only the long instruction header is decoded [R2]
                    if (cnt_q == `SPC_INSTR_LAST) begin
                        st_q   <= SPC_ST_DATA;
                        cnt_q  <= 4'h0;
                        rd_q   <= instr[`SPC_RW_BIT];
                        addr_q <= instr[12:0];
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                SPC_ST_DATA: begin
                    if (cnt_q == `SPC_BYTE_LAST) begin
                        cnt_q  <= 4'h0;
                        addr_q <= lnk.lsb_first ? addr_q + 13'h0001
                                                : addr_q - 13'h0001; // [R5]
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
            endcase
        end
    end

    // =========================================================
    // transmit side, launched on the falling edge
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            o_sdio_o    <= 1'b0;
            o_sdo_o     <= 1'b0;
            o_sdio_oe_n <= 1'b1;
            o_sdo_oe_n  <= 1'b1;
        end else begin
            o_sdio_o    <= tx_bit;
            o_sdo_o     <= tx_bit;
            o_sdio_oe_n <= !(drive && !lnk.sep_read_pin); // [R6]
            o_sdo_oe_n  <= !(drive && lnk.sep_read_pin); // [R6]
        end
    end
endmodule : spc_serial_engine

// ===== spc_serial_port.sv
// serial port configuration block: register file, bank choice and crossings
//
// Overview of operation
// R1: the host writes the upper nibble of the setup register as the mirror of the lower one.
// R2: only 16-bit instruction headers are decoded and the long-instruction bit resets to one.
// R3: setting soft reset returns the internal configuration registers to their defaults.
// R4: soft reset holds as long as the bit reads one and ends only when the host clears it.
// R5: bit order zero shifts msb first with falling addresses, one shifts lsb first rising.
// R6: separate-read-pin zero reads on the data pin, one reads on the read-out pin only.
// R7: a fixed read-only variant code sits at its own address and ignores writes.
// R8: bank choice zero reads back buffered copies, one reads back the active copies.
// R9: writing one to the update bit transfers buffered settings and the bit clears itself.
// R10: host writes land in the buffered copy and only the update makes them active; here only the bank register is buffered, setup writes act at once.
`include "spc_regs.svh"
module spc_serial_port import spc_pkg::*; #(
    // arbitrary value, stands in for the part's variant code
    parameter spc_byte_t VARIANT_CODE = 8'h5a
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_sclk,
    input  wire logic i_cs_n,
    input  wire logic i_serial_data_io_i,
    output logic      o_serial_data_io_o,
    output logic      o_serial_data_io_oe_n,
    output logic      o_serial_read_out_pin_o,
    output logic      o_serial_read_out_pin_oe_n,
    output logic      o_lsb_first,
    output logic      o_separate_read_pin_enable,
    output logic      o_soft_reset,
    output logic      o_readback_active,
    output logic      o_update_pulse
);
    spc_link_if lnk ();

    // =========================================================
    // reset request into the serial clock domain
    // the serial clock only runs inside frames, so the request is held
    // until the serial side has seen it and answered
    logic      rst_req_q;
    logic      rst_s1_q;
    logic      rst_s2_q;
    logic      ack_s1_q;
    logic      ack_s2_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rst_req_q <= 1'b1;
        end else if (ack_s2_q) begin
            rst_req_q <= 1'b0;
        end
    end

    always_ff @(posedge i_sclk) begin
        rst_s1_q <= rst_req_q;
        rst_s2_q <= rst_s1_q;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= rst_s2_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    // =========================================================
    // register file on the serial clock
    spc_byte_t setup_q;
    spc_byte_t bank_buf_q;
    spc_byte_t bank_act_q;
    logic      upd_tgl_q;
    logic      srst;
    logic      wr_setup;
    logic      wr_bank;
    logic      wr_update;
    logic      srst_wr;

    assign srst      = setup_q[`SPC_SETUP_SRST_BIT];
    assign wr_setup  = lnk.wr_en && (lnk.addr == `SPC_ADDR_SETUP);
    assign wr_bank   = lnk.wr_en && (lnk.addr == `SPC_ADDR_BANK);
    assign wr_update = lnk.wr_en && (lnk.addr == `SPC_ADDR_UPDATE)
                       && lnk.wdata[`SPC_UPDATE_BIT];
    // a soft reset write clears the bank copies at the same edge, since
    // the serial clock may stop right after it
    assign srst_wr   = wr_setup && lnk.wdata[`SPC_SETUP_SRST_BIT];

    // setup acts at once, since it governs the port that writes it
    always_ff @(posedge i_sclk) begin
        if (rst_s2_q) begin
            setup_q <= `SPC_SETUP_RST;
        end else if (wr_setup) begin
            // nibbles stored as written except on a soft reset write, mirroring is the host's duty [R1]
            if (lnk.wdata[`SPC_SETUP_SRST_BIT]) begin
                setup_q <= `SPC_SETUP_SRST_VAL | `SPC_SETUP_RST; // [R3]
            end else begin
                setup_q <= lnk.wdata; // [R4]
            end
        end
    end

    always_ff @(posedge i_sclk) begin
        if (rst_s2_q || srst || srst_wr) begin
            bank_buf_q <= `SPC_BANK_RST; // [R3] [R4]
        end else if (wr_bank) begin
            bank_buf_q <= lnk.wdata; // [R10]
        end
    end

    always_ff @(posedge i_sclk) begin
        if (rst_s2_q || srst || srst_wr) begin
            bank_act_q <= `SPC_BANK_RST; // [R3] [R4]
        end else if (wr_update) begin
            bank_act_q <= bank_buf_q; // [R9] [R10]
        end
    end

    // update bit is never stored, so it always reads back as zero
    always_ff @(posedge i_sclk) begin
        if (rst_s2_q) begin
            upd_tgl_q <= 1'b0;
        end else if (wr_update && !srst) begin
            upd_tgl_q <= !upd_tgl_q; // [R9]
        end
    end

    always_comb begin
        lnk.lsb_first    = setup_q[`SPC_SETUP_LSB_BIT]; // [R5]
        lnk.sep_read_pin = setup_q[`SPC_SETUP_SEP_BIT]; // [R6]
        unique case (lnk.addr)
            `SPC_ADDR_SETUP:   lnk.rdata = setup_q;
            `SPC_ADDR_VARIANT: lnk.rdata = VARIANT_CODE; // [R7]
            `SPC_ADDR_BANK: begin
                lnk.rdata = bank_act_q[`SPC_BANK_ACT_BIT] ? bank_act_q
                                                          : bank_buf_q; // [R8]
            end
            default:           lnk.rdata = `SPC_READ_ZERO;
        endcase
    end

    // =========================================================
    // serial engine
    spc_serial_engine u_engine (
        .i_sclk      (i_sclk),
        .i_cs_n      (i_cs_n),
        .i_sdi       (i_serial_data_io_i),
        .lnk         (lnk),
        .o_sdio_o    (o_serial_data_io_o),
        .o_sdio_oe_n (o_serial_data_io_oe_n),
        .o_sdo_o     (o_serial_read_out_pin_o),
        .o_sdo_oe_n  (o_serial_read_out_pin_oe_n)
    );

    // =========================================================
    // active settings into the system clock domain
    // single-bit levels, each through its own pair of flip-flops
    logic [3:0] lvl_s1_q;
    logic [3:0] lvl_s2_q;
    logic [2:0] upd_s_q;
    logic       side_held;

    // serial registers are unknown until the first frame after reset,
    // so the crossings stay cleared until the reset handshake has finished
    assign side_held = rst_req_q || ack_s2_q;

    always_ff @(posedge i_clk) begin
        if (i_rst || side_held) begin
            lvl_s1_q <= 4'h0;
            lvl_s2_q <= 4'h0;
        end else begin
            lvl_s1_q <= {bank_act_q[`SPC_BANK_ACT_BIT], srst,
                         setup_q[`SPC_SETUP_SEP_BIT], setup_q[`SPC_SETUP_LSB_BIT]};
            lvl_s2_q <= lvl_s1_q;
        end
    end

    // update toggle, edge taken between the second and third stage
    always_ff @(posedge i_clk) begin
        if (i_rst || side_held) begin
            upd_s_q <= 3'h0;
        end else begin
            upd_s_q <= {upd_s_q[1:0], upd_tgl_q};
        end
    end

    // =========================================================
    // outputs, one flop each
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_lsb_first <= 1'b0;
        end else begin
            o_lsb_first <= lvl_s2_q[0]; // [R5]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_separate_read_pin_enable <= 1'b0;
        end else begin
            o_separate_read_pin_enable <= lvl_s2_q[1]; // [R6]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_soft_reset <= 1'b0;
        end else begin
            o_soft_reset <= lvl_s2_q[2]; // [R4]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_readback_active <= 1'b0;
        end else begin
            o_readback_active <= lvl_s2_q[3]; // [R8]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_update_pulse <= 1'b0;
        end else begin
            o_update_pulse <= upd_s_q[2] ^ upd_s_q[1]; // [R9]
        end
    end
endmodule : spc_serial_port

// ===== spc_serial_port_properties.sv
// concurrent checks on the ports of the serial port configuration block
module spc_serial_port_properties (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic o_serial_data_io_oe_n,
    input wire logic o_serial_read_out_pin_oe_n,
    input wire logic o_lsb_first,
    input wire logic o_separate_read_pin_enable,
    input wire logic o_soft_reset,
    input wire logic o_readback_active,
    input wire logic o_update_pulse
);
    // ====================
    // helper: cycles since the last update pulse, saturating
    logic [3:0] gap_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) gap_q <= 4'hf;
        else if (o_update_pulse) gap_q <= 4'h0;
        else if (gap_q != 4'hf) gap_q <= gap_q + 4'h1;
    end
    // ====================
    // assertions
    idle_pins_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_cs_n && $past(i_cs_n) |-> o_serial_data_io_oe_n && o_serial_read_out_pin_oe_n)
        else $error("pin driven outside a frame");
    one_driver_a: assert property (@(posedge i_sclk) disable iff (i_cs_n)
        !o_serial_read_out_pin_oe_n |-> o_serial_data_io_oe_n)
        else $error("both data pins driven");
    upd_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_update_pulse |=> !o_update_pulse)
        else $error("update pulse longer than one cycle");
    bank_cause_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_readback_active) |-> (gap_q < 4'h8) or (##[0:6] o_update_pulse))
        else $error("active bank changed without update");
    srst_bank_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_soft_reset && $past(o_soft_reset, 6) |-> !o_readback_active)
        else $error("active bank set during soft reset");
    srst_noupd_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_soft_reset && $past(o_soft_reset, 6) |-> !o_update_pulse)
        else $error("update pulse during soft reset");
    srst_dflt_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_soft_reset |-> !o_lsb_first && !o_separate_read_pin_enable)
        else $error("setup bits not at default in soft reset");
    rst_quiet_a: assert property (@(posedge i_clk)
        i_rst |=> !o_update_pulse && !o_soft_reset && !o_readback_active && !o_lsb_first)
        else $error("outputs not cleared by reset");
    // ====================
    // covers
    cov_upd_c: cover property (@(posedge i_clk) o_update_pulse);
    cov_srst_c: cover property (@(posedge i_clk) $rose(o_soft_reset));
    cov_sep_c: cover property (@(posedge i_sclk) !o_serial_read_out_pin_oe_n);
endmodule : spc_serial_port_properties

bind spc_serial_port spc_serial_port_properties i_props (.i_clk, .i_rst, .i_sclk, .i_cs_n,
    .o_serial_data_io_oe_n, .o_serial_read_out_pin_oe_n, .o_lsb_first,
    .o_separate_read_pin_enable, .o_soft_reset, .o_readback_active, .o_update_pulse);

// ===== spc_host_model.sv
// host serial controller model: frames, link clock and data pin level
module spc_host_model (
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_data_io,
    input  wire logic i_dev_o,
    input  wire logic i_dev_oe_n,
    input  wire logic i_read_pin_o,
    input  wire logic i_read_pin_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv_q = 1'b0;
    logic drv_en = 1'b0;
    logic read_pin;
    // a released line shows the inverse of the device's output, never a held copy
    assign o_data_io = !i_dev_oe_n ? i_dev_o : (drv_en ? drv_q : ~i_dev_o);
    assign read_pin  = !i_read_pin_oe_n ? i_read_pin_o : ~i_read_pin_o;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
    end
    // ====================
    // bit position in {header, data}: reversed whole header and bytes in lsb mode
    function automatic int pos(input int i, input logic ls);
        if (!ls) return 31 - i;
        if (i < 16) return 16 + i;
        return 8 - 8 * ((i - 16) / 8) + (i - 16) % 8;
    endfunction : pos
    task automatic xfer(input logic rd, input logic [12:0] a, input logic ls, input logic sp,
                        input int nb, input logic [15:0] wd, output logic [15:0] rdat);
        logic [31:0] tx;
        logic [31:0] rx;
        tx = {rd, 2'b00, a, wd};
        rx = '0;
        #1.3 o_cs_n = 1'b0;
        for (int i = 0; i < 16 + 8 * nb; i++) begin
            drv_en = !(rd && i > 15);
            drv_q = tx[pos(i, ls)];
            #6 o_sclk = 1'b1;
            rx[pos(i, ls)] = sp ? read_pin : o_data_io;
            #6 o_sclk = 1'b0;
        end
        #6 o_cs_n = 1'b1;
        drv_en = 1'b0;
        rdat = rx[15:0];
        #10;
    endtask : xfer
endmodule : spc_host_model

// ===== tb_spc_serial_port.sv
// self-checking bench for the serial port configuration block
module tb_spc_serial_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sclk, cs_n, dio, dio_o, dio_oe_n, rd_o, rd_oe_n;
    logic        lsb, sep, srst, act, upd;
    logic [15:0] rdat;
    int          errors = 0;
    int          checks = 0;
    int          upd_seen = 0;
    always #2.5 clk = ~clk;
    spc_serial_port #(.VARIANT_CODE(8'h5a)) i_dut (.i_clk(clk), .i_rst(rst), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_serial_data_io_i(dio), .o_serial_data_io_o(dio_o),
        .o_serial_data_io_oe_n(dio_oe_n), .o_serial_read_out_pin_o(rd_o),
        .o_serial_read_out_pin_oe_n(rd_oe_n), .o_lsb_first(lsb),
        .o_separate_read_pin_enable(sep), .o_soft_reset(srst),
        .o_readback_active(act), .o_update_pulse(upd));
    spc_host_model i_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_data_io(dio), .i_dev_o(dio_o),
        .i_dev_oe_n(dio_oe_n), .i_read_pin_o(rd_o), .i_read_pin_oe_n(rd_oe_n));
    // the update pulse is over before a write task returns, so it is counted here
    always @(negedge clk) begin
        if (upd === 1'b1) begin
            upd_seen++;
        end
    end
    // ====================
    // tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // the 3-edge crossing to i_clk is covered by the 4-cycle settle
    task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic ls);
        i_host.xfer(1'b0, a, ls, 1'b0, 1, {d, 8'h00}, rdat);
        repeat (4) @(posedge clk);
    endtask : wr
    task automatic rd(input logic [12:0] a, input int nb, input logic [15:0] exp,
                      input logic ls, input logic sp);
        i_host.xfer(1'b1, a, ls, sp, nb, 16'h0000, rdat);
        check($sformatf("read %h", a), rdat, exp);
    endtask : rd
    task automatic wait_upd(input int target);
        int n;
        for (n = 0; n < 20 && upd_seen < target; n++) @(posedge clk);
        if (n == 20) begin
            errors++;
            tally_and_finish();
        end
        repeat (4) @(posedge clk);
    endtask : wait_upd
    // ====================
    // sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd(13'h0000, 1, 16'h1800, 1'b0, 1'b0);
        rd(13'h0003, 1, 16'h5a00, 1'b0, 1'b0);
        wr(13'h0003, 8'hff, 1'b0);
        rd(13'h0003, 1, 16'h5a00, 1'b0, 1'b0);
        wr(13'h0004, 8'h01, 1'b0);
        rd(13'h0004, 1, 16'h0100, 1'b0, 1'b0);
        check("active bank", 16'(act), 16'h0000);
        wr(13'h0232, 8'h01, 1'b0);
        wait_upd(1);
        check("update pulses", 16'(upd_seen), 16'h0001);
        check("active bank", 16'(act), 16'h0001);
        rd(13'h0232, 1, 16'h0000, 1'b0, 1'b0);
        rd(13'h0004, 2, 16'h015a, 1'b0, 1'b0);
        wr(13'h0004, 8'h00, 1'b0);
        rd(13'h0004, 1, 16'h0100, 1'b0, 1'b0);
        wr(13'h0000, 8'h5a, 1'b0);
        check("lsb first", 16'(lsb), 16'h0001);
        rd(13'h0003, 2, 16'h5a01, 1'b1, 1'b0);
        wr(13'h0000, 8'hdb, 1'b1);
        check("read pin mode", 16'(sep), 16'h0001);
        rd(13'h0000, 1, 16'hdb00, 1'b1, 1'b1);
        wr(13'h0000, 8'h3c, 1'b1);
        check("defaults", {12'h000, srst, lsb, sep, act}, 16'h0008);
        wr(13'h0004, 8'h01, 1'b0);
        wr(13'h0232, 8'h01, 1'b0);
        check("update in soft reset", 16'(upd_seen), 16'h0001);
        check("active bank", 16'(act), 16'h0000);
        rd(13'h0004, 1, 16'h0000, 1'b0, 1'b0);
        wr(13'h0000, 8'h18, 1'b0);
        check("soft reset", 16'(srst), 16'h0000);
        rd(13'h0000, 1, 16'h1800, 1'b0, 1'b0);
        rd(13'h0100, 1, 16'h0000, 1'b0, 1'b0);
        tally_and_finish();
    end
endmodule : tb_spc_serial_port
